// File: design/rst_wake_pkg.sv
// Shared constants and carriers for the reset and wake-up state initialiser.
package rst_wake_pkg;

  // ****************************************
  // Vectors and widths
  // ****************************************
  localparam int         PC_W           = 22;
  localparam int         SP_W           = 5;
  localparam logic [21:0] VEC_HIGH      = 22'h000008;
  localparam logic [21:0] VEC_LOW       = 22'h000018;
  localparam int         PC_TEST_BIT    = 21;
  localparam logic [4:0] SP_RESET       = 5'h00;
  localparam logic [7:0] TOP_RESET      = 8'h00;
  localparam logic [4:0] TOPU_RESET     = 5'h00;
  localparam logic [21:0] PC_RESET      = 22'h000000;

  // ****************************************
  // Port bit positions and masks
  // ****************************************
  localparam int         PA_BIT6        = 6;
  localparam int         PA_BIT7        = 7;
  localparam logic [7:0] PB_ANALOG_MASK = 8'h1F;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;
  localparam int         CFG3H_MASTER_CLEAR_INPUT_BIT = 7;
  localparam logic [7:0] CFG3H_RESET    = 8'h80;

  // ****************************************
  // Interrupt control reset values and priority enable bits
  // ****************************************
  localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
  localparam int         IRQ_HIGH_EN    = 7;
  localparam int         IRQ_LOW_EN     = 6;
  localparam logic [7:0] PIR_RESET      = 8'h00;

  // ****************************************
  // Oscillator mode codes
  // ****************************************
  typedef enum logic [3:0] {
    OSC_LP       = 4'h0,
    OSC_XT       = 4'h1,
    OSC_HS       = 4'h2,
    OSC_RC       = 4'h3,
    OSC_EC       = 4'h4,
    OSC_EXT_CLOCK_WITH_IO_MODE_M   = 4'h5,
    OSC_HSPLL    = 4'h6,
    OSC_RC_OSC_WITH_IO_MODE_M   = 4'h7,
    OSC_INT1     = 4'h8,
    OSC_INT2     = 4'h9
  } osc_mode_e;

  // Reset and wake event bundle.
  typedef struct packed {
    logic por;
    logic bor;
    logic master_clear_input;
    logic wdt;
    logic instr;
    logic stack;
    logic wake_wdt;
    logic wake_irq;
  } event_s;

  // Variant strap bundle.
  typedef struct packed {
    logic pins40;
    logic small_pkg;
    logic test_mode;
  } variant_s;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_PUSH  = 3'b010,
    ST_VECT  = 3'b100
  } seq_e;

endpackage

// File: design/bit_gate.sv
// Gated register bit slice that reads zero when disabled.
`timescale 1ns/1ps
module bit_gate #(
  parameter int W = 1
) (
  // Data
  input  wire logic [W-1:0] raw,
  input  wire logic         en,
  output logic      [W-1:0] gated
);

  always_comb begin
    gated = en ? raw : '0;
  end

endmodule

// File: design/stack_push.sv
// Return-stack top register and pointer with reset-class handling.
`timescale 1ns/1ps
module stack_push
  import rst_wake_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Control
  input  wire logic            cold,
  input  wire logic            warm,
  input  wire logic            push,
  input  wire logic [PC_W-1:0] pc_in,
  // State
  output logic      [PC_W-1:0] top,
  output logic      [SP_W-1:0] ptr
);

  logic [PC_W-1:0] next_top;
  logic [SP_W-1:0] next_ptr;

  always_comb begin
    next_top = top;
    next_ptr = ptr;
    if (cold || warm) begin
      next_top = {TOPU_RESET[0], TOPU_RESET, TOP_RESET, TOP_RESET};
      next_ptr = SP_RESET;
    end else if (push) begin
      next_top = pc_in;
      next_ptr = ptr + SP_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      top <= '0;
      ptr <= '0;
    end else begin
      top <= next_top;
      ptr <= next_ptr;
    end
  end

endmodule

// File: design/rst_wake_init.sv
// Architectural state set-up after reset and wake-up.
`timescale 1ns/1ps

module rst_wake_init
  import rst_wake_pkg::*;
(
  // Clock and reset
  input  wire logic            CLOCK,
  input  wire logic            RSTN,
  // Reset and wake events, one-cycle pulses, and variant straps
  input  wire event_s          EVENTS,
  input  wire variant_s        VARIANT,
  // Configuration
  input  wire osc_mode_e       OSC_MODE,
  input  wire logic            PB_ANALOG_CFG,
  input  wire logic [7:0]      CFG3H,
  input  wire logic            HIGH_PRIO_WAKE,
  input  wire logic [7:0]      PIR_WAKE_BITS,
  input  wire logic [7:0]      IRQ_WAKE_BITS,
  input  wire logic [PC_W-1:0] PC_NOW,
  // Raw port and capture values
  input  wire logic [7:0]      PA_PIN_IN,
  input  wire logic [7:0]      PB_PIN_IN,
  input  wire logic            PE3_PIN_IN,
  input  wire logic [7:0]      CAPTURE_IN,
  // Register bus
  input  wire logic [3:0]      ADDR,
  input  wire logic [7:0]      WDATA,
  input  wire logic            WR,
  input  wire logic            RD,
  output logic      [7:0]      RDATA,
  // State outputs
  output logic      [PC_W-1:0] PC,
  output logic                 PC_LOAD,
  output logic      [PC_W-1:0] STACK_TOP,
  output logic      [SP_W-1:0] STACK_PTR,
  output logic      [7:0]      IRQ_CTRL,
  output logic      [7:0]      PERIPH_IRQ_REQUEST_REG,
  output logic      [7:0]      PA_LATCH_OUT,
  output logic      [7:0]      PA_DIR_OUT,
  output logic                 PE3_IN_EN
);

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] A_IRQ   = 4'h0;
  localparam logic [3:0] A_PIR   = 4'h1;
  localparam logic [3:0] A_PA    = 4'h2;
  localparam logic [3:0] A_PORT_A_LATCH  = 4'h3;
  localparam logic [3:0] A_DIRA  = 4'h4;
  localparam logic [3:0] A_PB    = 4'h5;
  localparam logic [3:0] A_CAP   = 4'h6;
  localparam logic [3:0] A_PE    = 4'h7;
  localparam logic [3:0] A_STKLO = 4'h8;
  localparam logic [3:0] A_STKPT = 4'h9;

  // ****************************************
  // Reset classes
  // ****************************************
  logic cold;
  logic warm;
  logic wake_vec;
  assign cold = EVENTS.por | EVENTS.bor;
  assign warm = EVENTS.master_clear_input | EVENTS.wdt | EVENTS.instr | EVENTS.stack;
  assign wake_vec = EVENTS.wake_irq &
                    (IRQ_CTRL[IRQ_HIGH_EN] | IRQ_CTRL[IRQ_LOW_EN]);

  // ****************************************
  // Pin enables
  // ****************************************
  logic pa6_en;
  logic pa7_en;
  logic cap_en;
  logic pe3_en;

  always_comb begin
    case (OSC_MODE)
      OSC_RC_OSC_WITH_IO_MODE_M, OSC_EXT_CLOCK_WITH_IO_MODE_M, OSC_INT2: pa6_en = 1'b1;
      default:                          pa6_en = 1'b0;
    endcase
  end
  assign pa7_en = (OSC_MODE == OSC_INT2);
  assign cap_en = !VARIANT.small_pkg;
  assign pe3_en = VARIANT.pins40 & !CFG3H[CFG3H_MASTER_CLEAR_INPUT_BIT];

  // ****************************************
  // Sequencer and state
  // ****************************************
  seq_e            state;
  seq_e            next_state;
  logic [PC_W-1:0] next_pc;
  logic            next_pc_load;
  logic [7:0]      next_irq;
  logic [7:0]      next_pir;
  logic [7:0]      next_lat;
  logic [7:0]      next_dir;
  logic            pb_analog;
  logic            next_pb_analog;
  logic            push;
  logic [PC_W-1:0] stk_top;
  logic [SP_W-1:0] stk_ptr;

  assign push = (state == ST_PUSH);

  always_comb begin
    next_state     = state;
    next_pc        = PC;
    next_pc_load   = 1'b0;
    next_irq       = IRQ_CTRL;
    next_pir       = PERIPH_IRQ_REQUEST_REG;
    next_lat       = PA_LATCH_OUT;
    next_dir       = PA_DIR_OUT;
    next_pb_analog = pb_analog;
    if (WR) begin
      case (ADDR)
        A_IRQ:   next_irq = WDATA;
        A_PIR:   next_pir = WDATA;
        A_PORT_A_LATCH:  next_lat = WDATA;
        A_DIRA:  next_dir = WDATA;
        default: ;
      endcase
    end
    if (EVENTS.wake_irq || EVENTS.wake_wdt) begin
      next_irq = next_irq | IRQ_WAKE_BITS;
      next_pir = next_pir | PIR_WAKE_BITS;
    end
    case (state)
      ST_RUN: begin
        // A wake beside a reset pulse is dropped, because the reset class wins.
        if (wake_vec && !cold && !warm) begin
          next_state = ST_PUSH;
        end
      end
      ST_PUSH: begin
        next_state = ST_VECT;
      end
      ST_VECT: begin
        next_pc      = HIGH_PRIO_WAKE ? VEC_HIGH : VEC_LOW;
        next_pc_load = 1'b1;
        next_state   = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
    if (cold || warm) begin
      next_state     = ST_RUN;
      next_pc        = PC_RESET;
      next_pc_load   = 1'b1;
      next_irq       = IRQ_CTRL_RESET;
      next_pir       = PIR_RESET;
      next_lat       = ZERO_BYTE;
      next_dir       = ~ZERO_BYTE;
      next_pb_analog = PB_ANALOG_CFG;
    end
    if (!VARIANT.test_mode) begin
      next_pc[PC_TEST_BIT] = 1'b0;
    end
    if (!pa6_en) begin
      next_lat[PA_BIT6] = 1'b0;
      next_dir[PA_BIT6] = 1'b0;
    end
    if (!pa7_en) begin
      next_lat[PA_BIT7] = 1'b0;
      next_dir[PA_BIT7] = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state        <= ST_RUN;
      PC           <= PC_RESET;
      PC_LOAD      <= 1'b0;
      IRQ_CTRL     <= IRQ_CTRL_RESET;
      PERIPH_IRQ_REQUEST_REG          <= PIR_RESET;
      PA_LATCH_OUT <= ZERO_BYTE;
      PA_DIR_OUT   <= ZERO_BYTE;
      pb_analog    <= 1'b1;
    end else begin
      state        <= next_state;
      PC           <= next_pc;
      PC_LOAD      <= next_pc_load;
      IRQ_CTRL     <= next_irq;
      PERIPH_IRQ_REQUEST_REG          <= next_pir;
      PA_LATCH_OUT <= next_lat;
      PA_DIR_OUT   <= next_dir;
      pb_analog    <= next_pb_analog;
    end
  end

  // ****************************************
  // Stack capture value
  // ****************************************
  logic [PC_W-1:0] pc_push;

  // The pushed copy obeys the same bit 21 limit as the counter, so outside test mode a return can
  // never land in the test-only half of the program space.
  always_comb begin
    pc_push = PC_NOW;
    if (!VARIANT.test_mode) begin
      pc_push[PC_TEST_BIT] = 1'b0;
    end
  end

  // The stack is captured one cycle before the vector so the pushed value is the
  // interrupted pc, not the vector.
  stack_push u_stack (
    .clk   (CLOCK),
    .rst_n (RSTN),
    .cold  (cold),
    .warm  (warm),
    .push  (push),
    .pc_in (pc_push),
    .top   (stk_top),
    .ptr   (stk_ptr)
  );

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] pa_gated;
  logic [7:0] pb_read;
  logic [7:0] cap_read;
  logic [7:0] next_rdata;

  bit_gate #(.W(1)) u_pa6 (
    .raw   (PA_PIN_IN[PA_BIT6]),
    .en    (pa6_en),
    .gated (pa_gated[PA_BIT6])
  );
  bit_gate #(.W(1)) u_pa7 (
    .raw   (PA_PIN_IN[PA_BIT7]),
    .en    (pa7_en),
    .gated (pa_gated[PA_BIT7])
  );
  bit_gate #(.W(8)) u_cap (
    .raw   (CAPTURE_IN),
    .en    (cap_en),
    .gated (cap_read)
  );
  assign pa_gated[5:0] = PA_PIN_IN[5:0];

  assign pb_read = pb_analog ? (PB_PIN_IN & ~PB_ANALOG_MASK) : PB_PIN_IN;

  // Read data are zero outside the read slot, so a stale value is never
  // mistaken for a fresh one by software polling the bus.
  always_comb begin
    next_rdata = ZERO_BYTE;
    if (RD) begin
      case (ADDR)
        A_IRQ:   next_rdata = IRQ_CTRL;
        A_PIR:   next_rdata = PERIPH_IRQ_REQUEST_REG;
        A_PA:    next_rdata = pa_gated;
        A_PORT_A_LATCH:  next_rdata = PA_LATCH_OUT;
        A_DIRA:  next_rdata = PA_DIR_OUT;
        A_PB:    next_rdata = pb_read;
        A_CAP:   next_rdata = cap_read;
        A_PE:    next_rdata = {4'h0, PE3_PIN_IN & pe3_en, 3'h0};
        A_STKLO: next_rdata = stk_top[7:0];
        A_STKPT: next_rdata = {3'h0, stk_ptr};
        default: next_rdata = ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA     <= ZERO_BYTE;
      STACK_TOP <= '0;
      STACK_PTR <= '0;
      PE3_IN_EN <= 1'b0;
    end else begin
      RDATA     <= next_rdata;
      STACK_TOP <= stk_top;
      STACK_PTR <= stk_ptr;
      PE3_IN_EN <= pe3_en;
    end
  end

endmodule

// File: sim/rst_wake_checker.sv
// Port-level property checker for the reset and wake-up state initialiser.
`timescale 1ns/1ps
module rst_wake_checker
  import rst_wake_pkg::*;
(
  // Clock and reset
  input wire logic            CLOCK,
  input wire logic            RSTN,
  // Watched inputs
  input wire event_s          EVENTS,
  input wire variant_s        VARIANT,
  input wire osc_mode_e       OSC_MODE,
  input wire logic [7:0]      CFG3H,
  input wire logic            HIGH_PRIO_WAKE,
  input wire logic [7:0]      PIR_WAKE_BITS,
  input wire logic [PC_W-1:0] PC_NOW,
  input wire logic [3:0]      ADDR,
  input wire logic            RD,
  // Watched outputs
  input wire logic [7:0]      RDATA,
  input wire logic [PC_W-1:0] PC,
  input wire logic            PC_LOAD,
  input wire logic [PC_W-1:0] STACK_TOP,
  input wire logic [SP_W-1:0] STACK_PTR,
  input wire logic [7:0]      IRQ_CTRL,
  input wire logic [7:0]      PERIPH_IRQ_REQUEST_REG,
  input wire logic [7:0]      PA_DIR_OUT,
  input wire logic            PE3_IN_EN
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  logic wake_go;
  assign wake_go = EVENTS.wake_irq && IRQ_CTRL[7:6] != 2'b00;

  a_vector_high: assert property (
    wake_go && HIGH_PRIO_WAKE |-> ##3 PC_LOAD && PC == VEC_HIGH)
    else $error("High vector not loaded.");
  a_stack_push: assert property (
    wake_go |-> ##3 STACK_PTR == $past(STACK_PTR, 3) + 5'h01
      && STACK_TOP == ($past(PC_NOW, 2) & {VARIANT.test_mode, 21'h1FFFFF}))
    else $error("Wake push wrong.");
  a_stack_bit21: assert property (
    wake_go && !VARIANT.test_mode |-> ##3 !STACK_TOP[PC_TEST_BIT])
    else $error("Pushed pc kept test-only bit.");
  a_wake_flags: assert property (
    EVENTS.wake_wdt || wake_go |=> (PERIPH_IRQ_REQUEST_REG & $past(PIR_WAKE_BITS)) == $past(PIR_WAKE_BITS))
    else $error("Wake flags not set.");
  a_pa_bit7: assert property (
    PA_DIR_OUT[7] |-> OSC_MODE == OSC_INT2 || $past(OSC_MODE) == OSC_INT2)
    else $error("Port A bit 7 live in wrong mode.");
  a_pe3_gate: assert property (
    PE3_IN_EN |-> $past(VARIANT.pins40) && !$past(CFG3H[CFG3H_MASTER_CLEAR_INPUT_BIT]))
    else $error("Port E input enabled wrongly.");
  a_reset_pc: assert property (
    |EVENTS[7:2] |-> ##[1:2] PC_LOAD && PC == PC_RESET)
    else $error("Reset did not clear pc.");
  a_small_capture: assert property (
    RD && ADDR == 4'h6 && VARIANT.small_pkg |=> RDATA == 8'h00)
    else $error("Absent capture reads nonzero.");
  a_rdata_idle: assert property (
    !RD |=> RDATA == 8'h00)
    else $error("Read data outside read slot.");
endmodule

bind rst_wake_init rst_wake_checker chk_u (.CLOCK, .RSTN, .EVENTS, .VARIANT, .OSC_MODE,
  .CFG3H, .HIGH_PRIO_WAKE, .PIR_WAKE_BITS, .PC_NOW, .ADDR, .RD, .RDATA, .PC, .PC_LOAD,
  .STACK_TOP, .STACK_PTR, .IRQ_CTRL, .PERIPH_IRQ_REQUEST_REG, .PA_DIR_OUT, .PE3_IN_EN);

// File: sim/testbench.sv
// Self-checking bench for the reset and wake-up state initialiser.
`timescale 1ns/1ps
module testbench import rst_wake_pkg::*;;
  // ****************
  // Stimulus and outputs
  // ****************
  logic            CLOCK = 0, RSTN = 0, WR = 0, RD = 0, HIGH_PRIO_WAKE = 0;
  logic            PB_ANALOG_CFG = 1, PE3_PIN_IN = 1, PC_LOAD, PE3_IN_EN;
  logic [3:0]      ADDR = 4'h0;
  logic [7:0]      WDATA = 8'h00, CFG3H = 8'h80, PIR_WAKE_BITS = 8'h00, IRQ_WAKE_BITS = 8'h00;
  logic [7:0]      PA_PIN_IN = 8'hFF, PB_PIN_IN = 8'hA5, CAPTURE_IN = 8'h3C;
  logic [7:0]      RDATA, IRQ_CTRL, PERIPH_IRQ_REQUEST_REG, PA_LATCH_OUT, PA_DIR_OUT;
  logic [PC_W-1:0] PC_NOW = 22'h012345, PC, STACK_TOP;
  logic [SP_W-1:0] STACK_PTR;
  event_s          EVENTS = '0;
  variant_s        VARIANT = 3'b100;
  osc_mode_e       OSC_MODE = OSC_LP;
  int              fails = 0, samples_checked = 0;

  rst_wake_init dut_u (.CLOCK, .RSTN, .EVENTS, .VARIANT, .OSC_MODE, .PB_ANALOG_CFG, .CFG3H,
    .HIGH_PRIO_WAKE, .PIR_WAKE_BITS, .IRQ_WAKE_BITS, .PC_NOW, .PA_PIN_IN, .PB_PIN_IN,
    .PE3_PIN_IN, .CAPTURE_IN, .ADDR, .WDATA, .WR, .RD, .RDATA, .PC, .PC_LOAD, .STACK_TOP,
    .STACK_PTR, .IRQ_CTRL, .PERIPH_IRQ_REQUEST_REG, .PA_LATCH_OUT, .PA_DIR_OUT, .PE3_IN_EN);

  always #4 CLOCK = ~CLOCK;

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string what, input logic [23:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 chk("read", RDATA, exp);
  endtask
  task automatic pulse(input event_s e);
    @(posedge CLOCK);
    EVENTS <= e;
    @(posedge CLOCK);
    EVENTS <= '0;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_wake(input logic hi);
    logic [SP_W-1:0] p;
    wr(4'h1, 8'h00);
    wr(4'h0, hi ? 8'h80 : 8'h40);
    HIGH_PRIO_WAKE <= hi;
    VARIANT <= {2'b10, !hi};
    PIR_WAKE_BITS <= 8'h21;
    IRQ_WAKE_BITS <= 8'h02;
    PC_NOW <= {1'b1, PC_NOW[20:0] + 21'h000102};
    tick(1);
    p = STACK_PTR;
    pulse(8'h01);
    tick(2);
    chk("vector", PC, hi ? VEC_HIGH : VEC_LOW);
    chk("load", PC_LOAD, 1'b1);
    chk("top", STACK_TOP, {!hi, PC_NOW[20:0]});
    chk("bit21", STACK_TOP[21], !hi);
    chk("ptr", STACK_PTR, 5'(p + 5'h01));
    chk("pir", PERIPH_IRQ_REQUEST_REG & 8'h21, 8'h21);
    chk("irq", IRQ_CTRL[1], 1'b1);
    rdc(4'h8, PC_NOW[7:0]);
    rdc(4'h9, 8'(5'(p + 5'h01)));
    $display("wake test done");
  endtask
  task automatic t_quiet();
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    pulse(8'h01);
    tick(2);
    chk("skip", PC_LOAD, 1'b0);
    wr(4'h1, 8'h00);
    pulse(8'h02);
    tick(1);
    chk("wdt", PERIPH_IRQ_REQUEST_REG & 8'h21, 8'h21);
    $display("quiet test done");
  endtask
  task automatic t_reset();
    pulse(8'h80);
    tick(3);
    chk("pc", PC, PC_RESET);
    chk("irq", IRQ_CTRL, 8'h00);
    chk("sp", STACK_PTR, SP_RESET);
    chk("dir", PA_DIR_OUT, 8'h3F);
    rdc(4'h5, {PB_PIN_IN[7:5], 5'h00});
    @(posedge CLOCK);
    PB_ANALOG_CFG <= 1'b0;
    pulse(8'h20);
    tick(3);
    rdc(4'h5, PB_PIN_IN);
    $display("reset test done");
  endtask
  task automatic t_osc();
    osc_mode_e  m[5] = '{OSC_LP, OSC_RC_OSC_WITH_IO_MODE_M, OSC_EXT_CLOCK_WITH_IO_MODE_M, OSC_INT2, OSC_INT1};
    logic [7:0] k;
    foreach (m[i]) begin
      @(posedge CLOCK);
      OSC_MODE <= m[i];
      k = {m[i] == OSC_INT2, m[i] inside {OSC_RC_OSC_WITH_IO_MODE_M, OSC_EXT_CLOCK_WITH_IO_MODE_M, OSC_INT2}, 6'h3F};
      wr(4'h3, 8'hFF);
      wr(4'h4, 8'hFF);
      rdc(4'h2, k);
      rdc(4'h3, k);
      rdc(4'h4, k);
      chk("latch", PA_LATCH_OUT, k);
    end
    $display("oscillator test done");
  endtask
  task automatic t_variant();
    rdc(4'h6, CAPTURE_IN);
    @(posedge CLOCK);
    VARIANT <= 3'b110;
    rdc(4'h6, 8'h00);
    @(posedge CLOCK);
    CFG3H <= 8'h00;
    tick(2);
    chk("pe3", PE3_IN_EN, 1'b1);
    rdc(4'h7, 8'h08);
    @(posedge CLOCK);
    VARIANT <= 3'b010;
    tick(2);
    chk("pe3", PE3_IN_EN, 1'b0);
    rdc(4'h7, 8'h00);
    rdc(4'hF, 8'h00);
    $display("variant test done");
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge CLOCK);
    RSTN <= 1'b1;
    tick(2);
    t_wake(1'b1);
    t_wake(1'b0);
    t_quiet();
    t_reset();
    t_osc();
    t_variant();
    print_verdict();
  end
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
endmodule
